// ==== design/overtemp_timer_pkg.sv ====
// Constants shared by the over-temperature duration timer design
`default_nettype none
package overtemp_timer_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FAN_SPEED_PULSE_INPUT_CONFIG = 8'h78; // Fan_speed_pulse_input measurement control
  localparam logic [7:0] ADDR_DUR_STATUS = 8'h79; // Assertion duration status
  localparam logic [7:0] ADDR_DUR_LIMIT = 8'h7a; // Assertion duration limit

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_DUR_STATUS = 8'h00;
  localparam logic [7:0] RESET_DUR_LIMIT = 8'h00;
  localparam logic [7:0] RESET_FAN_SPEED_PULSE_INPUT_CONFIG = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of the fan_speed_pulse_input measurement control register
  // ----------------------------------------------------------------
  localparam int FAST_RATE_BIT = 3; // Fast measurement rate
  localparam int CONT_CH1_BIT = 4; // First continuous-measurement bit
  localparam int LOCKABLE_MSB = 3; // Bits [3:0] freeze under the lock
  localparam logic [7:0] LOCK_KEEP_MASK = 8'h0f; // Bits kept while locked

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_KHZ = 20000; // 20 MHz clock
  localparam int unsigned STEP_US = 22760; // 22.76 ms per count step
  localparam int unsigned SLOW_PERIOD_US = 1000000; // Default once per second
  localparam int unsigned FAST_PERIOD_US = 250000; // Fast rate period
  // Scale the clock to cycles per microsecond first: the full product overflows 32 bits
  localparam int unsigned CLOCKS_PER_US = CLOCK_KHZ / 1000;
  localparam int unsigned STEP_CYCLES = STEP_US * CLOCKS_PER_US;
  localparam int unsigned SLOW_CYCLES = SLOW_PERIOD_US * CLOCKS_PER_US;
  localparam int unsigned FAST_CYCLES = FAST_PERIOD_US * CLOCKS_PER_US;
  localparam logic [7:0] MIN_REPORT_STEPS = 8'h02; // 45.52 ms in steps
  localparam logic [7:0] COUNT_MAX = 8'hff; // Saturation value

endpackage
`default_nettype wire

// ==== design/level_sync.sv ====
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Level in and out
  input wire logic asyncIn,
  output logic syncOut
);

  // ------------------------------------------------------------
  // Synchroniser stages
  // ------------------------------------------------------------
  logic stage1; // Only read by the second stage
  logic next_stage1;
  logic next_syncOut;

  // Next values simply shift along
  always_comb begin
    next_stage1 = asyncIn;
    next_syncOut = stage1;
  end

  // Register both stages
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= RESET_LEVEL;
      syncOut <= RESET_LEVEL;
    end else begin
      stage1 <= next_stage1;
      syncOut <= next_syncOut;
    end
  end

endmodule
`default_nettype wire

// ==== design/overtemp_assert_duration_timer.sv ====
// Over-temperature assertion duration timer with fan_speed_pulse_input measurement control
//
// Overview of operation
// RL1 - Set seen bit on assertion, clear on read
// RL2 - Beyond 45.52 ms, report 22.76 ms step count
// RL3 - Upper seven bits zero until 45.52 ms
// RL4 - Read/write 8-bit duration limit, 22.76 ms steps
// RL5 - Duration above limit raises fan4 overtemp flag
// RL6 - Zero limit flags immediately on assertion
// RL7 - Software sets limit 0xff when line outputs
// RL8 - Lock freezes fan_speed_pulse_input config bits [3:0]
// RL9 - Continuous bits stop pulse stretching per channel
// RL10 - Fast bit raises fan_speed_pulse_input measurement rate
// RL11 - Duration count saturates, never wraps
`timescale 1ns/1ns
`default_nettype none
module overtemp_assert_duration_timer
  import overtemp_timer_pkg::*;
#(
  parameter int unsigned STEP_CLKS = overtemp_timer_pkg::STEP_CYCLES,
  parameter int unsigned SLOW_CLKS = overtemp_timer_pkg::SLOW_CYCLES,
  parameter int unsigned FAST_CLKS = overtemp_timer_pkg::FAST_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Over-temperature line, active low, asynchronous
  input wire logic overtempLine_b,
  // Register access port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Configuration lock from the configuration register
  input wire logic configLock,
  // Interrupt status set pulse
  output logic fan4OvertempFlag,
  // Fan_speed_pulse_input measurement control
  output logic [3:0] continuousTach,
  output logic [3:0] pulseStretchEn,
  output logic tachFastRate,
  output logic tachMeasureStart
);
  import overtemp_timer_pkg::*;

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // ----------------------------------------------------------------
  // Reset release and line synchroniser
  // ----------------------------------------------------------------
  logic rstMeta_b; // First reset stage
  logic syncRst_b; // Released reset used everywhere else
  logic lineSync_b; // Synchronised line level

  // Reset asserts at once and releases two edges later
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      syncRst_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      syncRst_b <= rstMeta_b;
    end
  end

  // Line idles high, so the synchroniser resets to inactive
  level_sync #(.RESET_LEVEL(1'b1)) lineSyncInst (
    .clock(clock),
    .rst_b(syncRst_b),
    .asyncIn(overtempLine_b),
    .syncOut(lineSync_b)
  );

  // ----------------------------------------------------------------
  // Duration measurement state
  // ----------------------------------------------------------------
  logic lineActive; // Line asserted, after synchronising
  logic linePrev; // Line level one cycle ago
  logic lineRise; // First cycle of an assertion
  logic [31:0] stepCnt; // Clock cycles within the current step
  logic stepTick; // One step of assertion completed
  logic [7:0] durCount; // Assertion duration in steps
  logic seenLsb; // Sticky assertion-seen bit
  logic [7:0] durLimit; // Programmed duration limit
  logic overLimit; // Duration is beyond the limit now
  logic overLimitPrev; // Same, one cycle ago
  logic [7:0] statusView; // What a status read returns
  logic statusRead; // Status register is being read
  logic [31:0] next_stepCnt;
  logic [7:0] next_durCount;
  logic next_seenLsb;
  logic [7:0] next_durLimit;
  logic next_linePrev;
  logic next_overLimitPrev;
  logic next_fan4OvertempFlag;

  assign lineActive = ~lineSync_b;
  assign lineRise = lineActive & ~linePrev;
  assign stepTick = lineActive & (stepCnt == STEP_CLKS - 1);
  assign statusRead = regRead & hit(regAddr, ADDR_DUR_STATUS);

  // Short assertions show only the seen bit; longer ones the whole count
  always_comb begin
    if (durCount >= MIN_REPORT_STEPS) begin
      statusView = durCount; // [RL2]
    end else begin
      statusView = {7'h00, seenLsb}; // [RL3]
    end
  end

  // A zero limit fires as soon as the line is seen asserted
  always_comb begin
    if (durLimit == 8'h00) begin
      overLimit = lineActive; // [RL6]
    end else begin
      overLimit = lineActive & (durCount > durLimit); // [RL5]
    end
  end

  // Next values of the measurement state
  always_comb begin
    next_linePrev = lineActive;
    next_overLimitPrev = overLimit;
    next_fan4OvertempFlag = overLimit & ~overLimitPrev; // [RL5]
    // Step timer restarts with every assertion so steps align to it
    if (!lineActive || lineRise || stepTick) begin
      next_stepCnt = 32'h0;
    end else begin
      next_stepCnt = stepCnt + 32'h1;
    end
    // A read clears the count; a step in the same cycle still counts unless the count stood at COUNT_MAX
    next_durCount = statusRead ? 8'h00 : durCount;
    if (stepTick && durCount != COUNT_MAX) begin
      next_durCount = next_durCount + 8'h01; // [RL2] [RL11]
    end
    // Set wins over the clear of a simultaneous read
    next_seenLsb = (seenLsb & ~statusRead) | lineRise; // [RL1]
    // Limit register is plain read/write
    next_durLimit = durLimit;
    if (regWrite && hit(regAddr, ADDR_DUR_LIMIT)) begin
      next_durLimit = regWrData; // [RL4]
    end
  end

  // Register the measurement state
  always_ff @(posedge clock or negedge syncRst_b) begin
    if (!syncRst_b) begin
      stepCnt <= 32'h0;
      durCount <= RESET_DUR_STATUS;
      seenLsb <= 1'b0;
      durLimit <= RESET_DUR_LIMIT;
      linePrev <= 1'b0;
      overLimitPrev <= 1'b0;
      fan4OvertempFlag <= 1'b0;
    end else begin
      stepCnt <= next_stepCnt;
      durCount <= next_durCount;
      seenLsb <= next_seenLsb;
      durLimit <= next_durLimit;
      linePrev <= next_linePrev;
      overLimitPrev <= next_overLimitPrev;
      fan4OvertempFlag <= next_fan4OvertempFlag;
    end
  end

  // ----------------------------------------------------------------
  // Fan_speed_pulse_input measurement control
  // ----------------------------------------------------------------
  logic [7:0] tachConfig; // Fan_speed_pulse_input measurement control register
  logic [31:0] rateCnt; // Cycles since the last measurement start
  logic [31:0] ratePeriod; // Selected measurement period
  logic [7:0] next_tachConfig;
  logic [31:0] next_rateCnt;
  logic next_tachMeasureStart;

  assign ratePeriod = tachConfig[FAST_RATE_BIT] ? FAST_CLKS : SLOW_CLKS; // [RL10]
  assign tachFastRate = tachConfig[FAST_RATE_BIT];
  assign continuousTach = tachConfig[CONT_CH1_BIT +: 4];

  // Each continuous channel keeps its drive output unstretched
  for (genvar ch = 0; ch < 4; ch++) begin : gStretch
    assign pulseStretchEn[ch] = ~tachConfig[CONT_CH1_BIT + ch]; // [RL9]
  end

  // Next values of the fan_speed_pulse_input control state
  always_comb begin
    next_tachConfig = tachConfig;
    if (regWrite && hit(regAddr, ADDR_FAN_SPEED_PULSE_INPUT_CONFIG)) begin
      if (configLock) begin
        // Locked: lower nibble keeps its value, upper bits still write
        next_tachConfig = (tachConfig & LOCK_KEEP_MASK) | (regWrData & ~LOCK_KEEP_MASK); // [RL8]
      end else begin
        next_tachConfig = regWrData;
      end
    end
    // Period change takes effect at once; the running count is compared with the new period
    if (rateCnt >= ratePeriod - 1) begin
      next_rateCnt = 32'h0;
      next_tachMeasureStart = 1'b1; // [RL10]
    end else begin
      next_rateCnt = rateCnt + 32'h1;
      next_tachMeasureStart = 1'b0;
    end
  end

  // Register the fan_speed_pulse_input control state
  always_ff @(posedge clock or negedge syncRst_b) begin
    if (!syncRst_b) begin
      tachConfig <= RESET_FAN_SPEED_PULSE_INPUT_CONFIG;
      rateCnt <= 32'h0;
      tachMeasureStart <= 1'b0;
    end else begin
      tachConfig <= next_tachConfig;
      rateCnt <= next_rateCnt;
      tachMeasureStart <= next_tachMeasureStart;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] next_regRdData;

  // Unmapped addresses read as zero; data holds until the next read
  always_comb begin
    next_regRdData = regRdData;
    if (regRead) begin
      case (regAddr)
        ADDR_DUR_STATUS: begin
          next_regRdData = statusView; // [RL1]
        end
        ADDR_DUR_LIMIT: begin
          next_regRdData = durLimit;
        end
        ADDR_FAN_SPEED_PULSE_INPUT_CONFIG: begin
          next_regRdData = tachConfig;
        end
        default: begin
          next_regRdData = 8'h00;
        end
      endcase
    end
  end

  // Register the read data
  always_ff @(posedge clock or negedge syncRst_b) begin
    if (!syncRst_b) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= next_regRdData;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence sLineRise;
    lineRise;
  endsequence

  sequence sZeroLimitRise;
    sLineRise ##0 (durLimit == 8'h00);
  endsequence

  a_seen_on_assert: assert property (@(posedge clock) disable iff (!syncRst_b) // [RL1]
    sLineRise |=> seenLsb [*2] or (seenLsb ##1 $fell(seenLsb)))
    else $error("seen bit not set on assertion");

  a_read_clears_seen: assert property (@(posedge clock) disable iff (!syncRst_b) // [RL1]
    (statusRead && !lineRise) |=> !seenLsb && durCount <= 8'h01)
    else $error("status read did not clear");

  a_upper_bits_zero: assert property (@(posedge clock) disable iff (!syncRst_b) // [RL3]
    (regRead && regAddr == ADDR_DUR_STATUS && durCount < MIN_REPORT_STEPS)
      |=> regRdData[7:1] == 7'h00)
    else $error("upper duration bits not zero");

  a_count_reported: assert property (@(posedge clock) disable iff (!syncRst_b) // [RL2]
    (statusRead && durCount >= MIN_REPORT_STEPS) |=> regRdData == $past(durCount))
    else $error("duration count not reported");

  a_count_steps: assert property (@(posedge clock) disable iff (!syncRst_b) // [RL2]
    (stepTick && !statusRead && durCount != COUNT_MAX) |=> durCount == $past(durCount) + 8'h01)
    else $error("duration count missed a step");

  a_count_saturates: assert property (@(posedge clock) disable iff (!syncRst_b) // [RL11]
    (durCount == COUNT_MAX && !statusRead) |=> durCount == COUNT_MAX)
    else $error("duration count wrapped");

  a_zero_limit_irq: assert property (@(posedge clock) disable iff (!syncRst_b) // [RL6]
    sZeroLimitRise |=> fan4OvertempFlag)
    else $error("zero limit did not flag at once");

  a_limit_flag: assert property (@(posedge clock) disable iff (!syncRst_b) // [RL5]
    (lineActive && durLimit != 8'h00 && durCount > durLimit && !overLimitPrev)
      |=> fan4OvertempFlag ##1 !fan4OvertempFlag)
    else $error("limit flag not a single pulse");

  a_lock_holds: assert property (@(posedge clock) disable iff (!syncRst_b) // [RL8]
    (configLock && regWrite && regAddr == ADDR_FAN_SPEED_PULSE_INPUT_CONFIG)
      |=> tachConfig[LOCKABLE_MSB:0] == $past(tachConfig[LOCKABLE_MSB:0]))
    else $error("locked fan_speed_pulse_input bits changed");

  a_stretch_follows: assert property (@(posedge clock) disable iff (!syncRst_b) // [RL9]
    (regWrite && regAddr == ADDR_FAN_SPEED_PULSE_INPUT_CONFIG)
      |=> pulseStretchEn == ~$past(regWrData[CONT_CH1_BIT +: 4]))
    else $error("stretch enable disagrees with written continuous bits");

endmodule
`default_nettype wire

// ==== tb/overtemp_source_model.sv ====
// Behavioural source that drives the active-low over-temperature line
`timescale 1ns/1ns
`default_nettype none
module overtemp_source_model (
  // Clock
  input wire logic clock,
  // Line towards the timer, idle high
  output logic overtempLine_b
);
  // ----------------------------------------
  // Line level
  // ----------------------------------------
  // Idle high from time zero so the timer never sees a false start
  initial overtempLine_b = 1'b1;

  // Hold the line asserted (low) for a number of clock cycles
  task automatic hold_low(input int cycles);
    @(posedge clock);
    #1 overtempLine_b = 1'b0;
    repeat (cycles) @(posedge clock);
    #1 overtempLine_b = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== tb/overtemp_assert_duration_timer_tb_top.sv ====
// Self-checking bench for the over-temperature duration timer
`timescale 1ns/1ns
`default_nettype none
module overtemp_assert_duration_timer_tb_top;
  import overtemp_timer_pkg::*;
  // ----------------------------------------
  // Shortened counts and bench signals
  // ----------------------------------------
  localparam int unsigned STEP = 8; // Cycles per duration step
  localparam int unsigned SLOW = 40; // Default fan_speed_pulse_input period
  localparam int unsigned FAST = 10; // Fast fan_speed_pulse_input period
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic overtempLine_b;
  logic [7:0] regAddr = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic configLock = 1'b0;
  logic fan4OvertempFlag;
  logic [3:0] continuousTach;
  logic [3:0] pulseStretchEn;
  logic tachFastRate;
  logic tachMeasureStart;
  int errCount = 0; // Mismatches seen
  int nChecks = 0; // Comparisons made
  int flagCount = 0; // Limit flag pulses seen
  logic [7:0] expQ[$]; // Expected read data, oldest first
  logic rdD1 = 1'b0;
  logic rdD2 = 1'b0;

  // ----------------------------------------
  // Clock, design and line source
  // ----------------------------------------
  always #25 clock = ~clock;

  overtemp_assert_duration_timer #(.STEP_CLKS(STEP), .SLOW_CLKS(SLOW), .FAST_CLKS(FAST))
    u_overtemp_assert_duration_timer (
    .clock(clock), .rst_b(rst_b), .overtempLine_b(overtempLine_b),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWrData(regWrData), .regRdData(regRdData), .configLock(configLock),
    .fan4OvertempFlag(fan4OvertempFlag), .continuousTach(continuousTach),
    .pulseStretchEn(pulseStretchEn), .tachFastRate(tachFastRate),
    .tachMeasureStart(tachMeasureStart));

  overtemp_source_model u_overtemp_source_model (.clock(clock), .overtempLine_b(overtempLine_b));

  // ----------------------------------------
  // Compare, verdict and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic closeOut();
    if (errCount == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One-cycle write strobe, request held across the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(posedge clock);
    #1 regWrite = 1'b0;
  endtask

  // One-cycle read strobe; the expectation goes to the monitor's queue
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    #1 regAddr = a;
    regRead = 1'b1;
    expQ.push_back(e);
    @(posedge clock);
    #1 regRead = 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Cycles between two fan_speed_pulse_input start pulses
  task automatic gap(output int g);
    time t0;
    do @(posedge clock); while (tachMeasureStart !== 1'b1);
    t0 = $time;
    do @(posedge clock); while (tachMeasureStart !== 1'b1);
    g = int'(($time - t0) / 50);
  endtask

  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  // Read data is settled by the second falling edge after the strobe
  always @(negedge clock) begin
    if (rdD2) begin
      chk({8'h00, regRdData}, {8'h00, expQ.pop_front()});
    end
    rdD2 = rdD1;
    rdD1 = regRead;
  end

  // The flag is a one-cycle pulse, so it is counted at every edge
  always @(posedge clock) begin
    if (fan4OvertempFlag === 1'b1) begin
      flagCount++;
    end
  end

  // Watchdog: the tests need about 2400 cycles
  initial begin
    #(20000 * 50);
    errCount++;
    closeOut();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int f0;
    int g;
    logic [7:0] d;
    logic [7:0] e;
    void'($urandom(32'hdf61));
    repeat (5) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clock);
    // Reset values and an unmapped address
    rd(ADDR_DUR_STATUS, RESET_DUR_STATUS);
    rd(ADDR_DUR_LIMIT, RESET_DUR_LIMIT);
    rd(ADDR_FAN_SPEED_PULSE_INPUT_CONFIG, RESET_FAN_SPEED_PULSE_INPUT_CONFIG);
    rd(8'h55, 8'h00);
    d = 8'($urandom);
    wr(ADDR_DUR_LIMIT, d);
    rd(ADDR_DUR_LIMIT, d);
    // Short assertion: only the seen bit shows, then read clears it
    wr(ADDR_DUR_LIMIT, 8'h03);
    f0 = flagCount;
    u_overtemp_source_model.hold_low(STEP + 4);
    repeat (4) @(posedge clock);
    rd(ADDR_DUR_STATUS, 8'h01);
    rd(ADDR_DUR_STATUS, 8'h00);
    chk(16'(flagCount - f0), 16'h0000);
    // Five steps crosses the limit of three exactly once
    f0 = flagCount;
    u_overtemp_source_model.hold_low(5 * STEP + 4);
    repeat (4) @(posedge clock);
    rd(ADDR_DUR_STATUS, 8'h05);
    chk(16'(flagCount - f0), 16'h0001);
    // Zero limit flags at once on a very short assertion
    wr(ADDR_DUR_LIMIT, 8'h00);
    f0 = flagCount;
    u_overtemp_source_model.hold_low(4);
    repeat (4) @(posedge clock);
    chk(16'(flagCount - f0), 16'h0001);
    rd(ADDR_DUR_STATUS, 8'h01);
    // Full-scale limit as software would set it; count must saturate
    wr(ADDR_DUR_LIMIT, 8'hff);
    f0 = flagCount;
    u_overtemp_source_model.hold_low(260 * STEP);
    repeat (4) @(posedge clock);
    rd(ADDR_DUR_STATUS, 8'hff);
    chk(16'(flagCount - f0), 16'h0000);
    // Fan_speed_pulse_input control: lock keeps the low nibble only
    d = 8'($urandom);
    e = 8'($urandom);
    wr(ADDR_FAN_SPEED_PULSE_INPUT_CONFIG, d);
    rd(ADDR_FAN_SPEED_PULSE_INPUT_CONFIG, d);
    configLock = 1'b1;
    wr(ADDR_FAN_SPEED_PULSE_INPUT_CONFIG, e);
    rd(ADDR_FAN_SPEED_PULSE_INPUT_CONFIG, {e[7:4], d[3:0]});
    chk({12'h000, continuousTach}, {12'h000, e[7:4]});
    chk({12'h000, pulseStretchEn}, {12'h000, ~e[7:4]});
    chk({15'h0000, tachFastRate}, {15'h0000, d[FAST_RATE_BIT]});
    configLock = 1'b0;
    // Measurement rate, fast then default; the first gap may straddle the switch
    wr(ADDR_FAN_SPEED_PULSE_INPUT_CONFIG, 8'h08);
    gap(g);
    gap(g);
    chk(16'(g), 16'(FAST));
    wr(ADDR_FAN_SPEED_PULSE_INPUT_CONFIG, 8'h00);
    gap(g);
    gap(g);
    chk(16'(g), 16'(SLOW));
    closeOut();
  end
endmodule
`default_nettype wire
